// ---- core/power_on_clock_out_sequencer.sv ----
// power-on and supply-drop sequencer with clock output and AXI4-Lite regs
// assumes supply comparator pins are asynchronous, nv inputs are stable
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module power_on_clock_out_sequencer #(
  parameter int unsigned POR_CYC = por_seq_pkg::POR_CYC,
  parameter int unsigned START_CYC = por_seq_pkg::START_CYC,
  parameter int unsigned DLY_32K_CYC = por_seq_pkg::DLY_32K_CYC,
  parameter int unsigned DLY_1K_CYC = por_seq_pkg::DLY_1K_CYC,
  parameter int unsigned DLY_64_CYC = por_seq_pkg::DLY_64_CYC,
  parameter int unsigned DLY_1HZ_CYC = por_seq_pkg::DLY_1HZ_CYC,
  parameter int unsigned DLY_HF_CYC = por_seq_pkg::DLY_HF_CYC,
  parameter int unsigned DEB_CYC = por_seq_pkg::DEB_CYC,
  parameter int unsigned SAMPLE_CYC = por_seq_pkg::SAMPLE_CYC
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic supplyBelowPor,
  input wire logic supplyBelowLow,
  input wire logic supplyBelowBus,
  input wire logic onBackup,
  input wire logic clockOutIrqFlag,
  input wire logic nvClockOutDisable,
  input wire logic [1:0] nvOutFreqSelect,
  input wire logic nvOscillatorSelect,
  input wire logic nvPowerOnIrqEnable,
  input wire logic [por_seq_pkg::HFD_W-1:0] nvHighFreqDivider,
  output logic clockOut,
  output logic clockOutEn,
  output logic intPin_n,
  output logic irq,
  output logic busEnable,
  output logic tempSenseEn,
  output logic mainActive,
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  import por_seq_pkg::*;

  logic [NPIN-1:0] sy1_q, sy2_q, sy3_q, lvl_q;
  seq_t seq_q;
  logic [31:0] seqCnt_q, dlyCnt_q, debCnt_q, secCnt_q;
  logic [31:0] ctrl_q;
  logic [2:0] status_q, irqEn_q, clrBits;
  logic clkActive_q, wantOn, secTick, wrGo, rdGo;
  logic [31:0] selDly, wrMask;
  logic [HFD_W:0] hfdPlus;
  nco_if nco ();

  clock_out_divider u_div (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .nco(nco)
  );

  // three-stage synchronisers, level taken once stages two and three agree
  for (genvar i = 0; i < NPIN; i++) begin : g_sync
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
      if (!arst_n)
      begin
        sy1_q[i] <= 1'b0;
        sy2_q[i] <= 1'b0;
        sy3_q[i] <= 1'b0;
        lvl_q[i] <= 1'b0;
      end
      else
      begin
        sy1_q[i] <= (i == PIN_POR) ? supplyBelowPor :
                    (i == PIN_LOWV) ? supplyBelowLow :
                    (i == PIN_BUSLOW) ? supplyBelowBus : onBackup;
        sy2_q[i] <= sy1_q[i];
        sy3_q[i] <= sy2_q[i];
        if (sy2_q[i] == sy3_q[i])
          lvl_q[i] <= sy3_q[i];
      end
    end
  end

  // start-up phases: hi-z, start-up with first refresh, running
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      seq_q <= SEQ_POR;
      seqCnt_q <= 32'h0000_0000;
    end
    else
    begin
      case (seq_q)
        SEQ_POR:
        begin
          seqCnt_q <= seqCnt_q + 32'h0000_0001;
          if (seqCnt_q >= POR_CYC - 1)
          begin
            seq_q <= SEQ_START;
            seqCnt_q <= 32'h0000_0000;
          end
        end
        SEQ_START:
        begin
          seqCnt_q <= seqCnt_q + 32'h0000_0001;
          if (seqCnt_q >= START_CYC - 1)
            seq_q <= SEQ_RUN;
        end
        SEQ_RUN: seq_q <= SEQ_RUN;
        default: seq_q <= SEQ_POR;
      endcase
    end
  end

  // bus handshakes: both write channels taken together, one at a time
  assign wrGo = awvalid && wvalid && !awready && !bvalid;
  assign rdGo = arvalid && !arready && !rvalid;
  assign wrMask = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}},
                   {8{wstrb[0]}}};
  assign clrBits = (wrGo && awaddr == ADDR_IRQ_CLR) ?
                   wdata[2:0] & wrMask[2:0] : 3'h0;

  // write channels; the response waits until both have been taken
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= 2'b00;
    end
    else
    begin
      awready <= wrGo;
      wready <= wrGo;
      if (awready) // address and data handshake done this edge
      begin
        bvalid <= 1'b1;
        bresp <= (awaddr == ADDR_CTRL || awaddr == ADDR_IRQ_EN ||
                  awaddr == ADDR_IRQ_CLR) ? 2'b00 : 2'b10;
      end
      else if (bvalid && bready)
        bvalid <= 1'b0;
    end
  end

  // control register, loaded from nonvolatile copy at end of start-up
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      ctrl_q <= CTRL_RST;
    else if (seq_q == SEQ_START && seqCnt_q >= START_CYC - 1)
    begin
      ctrl_q <= CTRL_RST;
      ctrl_q[CTRL_DIS] <= nvClockOutDisable;
      ctrl_q[CTRL_FD +: 2] <= nvOutFreqSelect;
      ctrl_q[CTRL_OS] <= nvOscillatorSelect;
      ctrl_q[CTRL_POWER_ON_IRQ_ENABLE] <= nvPowerOnIrqEnable;
      ctrl_q[CTRL_HFD +: HFD_W] <= nvHighFreqDivider;
    end
    else if (wrGo && awaddr == ADDR_CTRL)
      ctrl_q <= ((ctrl_q & ~wrMask) | (wdata & wrMask)) & CTRL_MASK;
  end

  // interrupt enable register
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      irqEn_q <= IRQ_EN_RST;
    else if (wrGo && awaddr == ADDR_IRQ_EN)
      irqEn_q <= (irqEn_q & ~wrMask[2:0]) | (wdata[2:0] & wrMask[2:0]);
  end

  // sticky status, a set in the clearing cycle wins
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      status_q <= STATUS_RST;
    else
    begin
      status_q <= (status_q & ~clrBits) |
                  {mainActive == 1'b0 && lvl_q[PIN_BACKUP] == 1'b0 &&
                   debDone(), lvl_q[PIN_LOWV], lvl_q[PIN_POR]};
    end
  end

  // recovery finishes after debounce or on a one-second sample
  function automatic logic debDone();
    debDone = status_q[ST_LOWV] ? secTick : (debCnt_q >= DEB_CYC - 1);
  endfunction

  // read channel
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= 2'b00;
    end
    else
    begin
      arready <= rdGo;
      if (arready) // data only after the address was taken
      begin
        rvalid <= 1'b1;
        rresp <= 2'b00;
        case (araddr)
          ADDR_CTRL: rdata <= ctrl_q;
          ADDR_STATUS: rdata <= {29'h0, status_q};
          ADDR_IRQ_EN: rdata <= {29'h0, irqEn_q};
          ADDR_IRQ_CLR: rdata <= 32'h0000_0000;
          ADDR_STATE: rdata <= {24'h0, mainActive, busEnable,
                                lvl_q[PIN_LOWV], clkActive_q, 2'b00, seq_q};
          default:
          begin
            rdata <= 32'h0000_0000;
            rresp <= 2'b10;
          end
        endcase
      end
      else if (rvalid && rready)
        rvalid <= 1'b0;
    end
  end

  // frequency and start delay selection
  assign hfdPlus = {1'b0, ctrl_q[CTRL_HFD +: HFD_W]} + 1'b1;
  always_comb
  begin
    nco.increment = INC_32K;
    selDly = DLY_32K_CYC;
    if (ctrl_q[CTRL_OS])
    begin
      nco.increment = 32'(INC_HF_STEP * 32'(hfdPlus));
      selDly = DLY_HF_CYC;
    end
    else
    begin
      case (freq_t'(ctrl_q[CTRL_FD +: 2]))
        FD_32K: nco.increment = INC_32K;
        FD_1K:
        begin
          nco.increment = INC_1K;
          selDly = DLY_1K_CYC;
        end
        FD_64:
        begin
          nco.increment = INC_64;
          selDly = DLY_64_CYC;
        end
        FD_1HZ:
        begin
          nco.increment = INC_1HZ;
          selDly = DLY_1HZ_CYC;
        end
        default: nco.increment = INC_32K;
      endcase
    end
  end

  // clock out wanted: running, not disabled unless flagged, supply fine
  assign wantOn = (seq_q == SEQ_RUN) && !lvl_q[PIN_LOWV] &&
                  (!ctrl_q[CTRL_DIS] || clockOutIrqFlag);
  assign nco.hold = !clkActive_q;

  // synchronised enable after the selected delay, wave from phase zero
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      clkActive_q <= 1'b0;
      dlyCnt_q <= 32'h0000_0000;
    end
    else if (!wantOn)
    begin
      clkActive_q <= 1'b0;
      dlyCnt_q <= 32'h0000_0000;
    end
    else if (!clkActive_q)
    begin
      dlyCnt_q <= dlyCnt_q + 32'h0000_0001;
      if (dlyCnt_q >= selDly - 1)
        clkActive_q <= 1'b1;
    end
  end

  // pin outputs
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      clockOut <= 1'b0;
      clockOutEn <= 1'b0;
      intPin_n <= 1'b1;
      irq <= 1'b0;
      busEnable <= 1'b0;
      tempSenseEn <= 1'b0;
    end
    else
    begin
      clockOutEn <= (seq_q != SEQ_POR);
      clockOut <= clkActive_q && nco.wave && wantOn;
      intPin_n <= !(status_q[ST_POR] && ctrl_q[CTRL_POWER_ON_IRQ_ENABLE]);
      irq <= |(status_q & irqEn_q);
      busEnable <= !lvl_q[PIN_BUSLOW] && seq_q != SEQ_POR;
      tempSenseEn <= (seq_q == SEQ_RUN) && !lvl_q[PIN_LOWV];
    end
  end

  // one-second sampling tick and recovery debounce
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      secCnt_q <= 32'h0000_0000;
      secTick <= 1'b0;
    end
    else
    begin
      secTick <= (secCnt_q >= SAMPLE_CYC - 1);
      secCnt_q <= (secCnt_q >= SAMPLE_CYC - 1) ? 32'h0000_0000 :
                  secCnt_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mainActive <= 1'b1;
      debCnt_q <= 32'h0000_0000;
    end
    else if (lvl_q[PIN_BACKUP])
    begin
      mainActive <= 1'b0;
      debCnt_q <= 32'h0000_0000;
    end
    else if (!mainActive)
    begin
      debCnt_q <= debCnt_q + 32'h0000_0001;
      if (debDone())
        mainActive <= 1'b1;
    end
  end

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  sequence s_enable_wait;
    wantOn && !clkActive_q ##0 dlyCnt_q == selDly - 1;
  endsequence

  a_por_hiz_pin: assert property (seq_q == SEQ_POR |=> !clockOutEn)
    else $error("clock out driven during reset interval");
  a_flag_set_drop: assert property (lvl_q[PIN_POR] |=> status_q[ST_POR])
    else $error("power-on flag not set on supply drop");
  a_flag_sticky: assert property (status_q[ST_POR] && !clrBits[ST_POR]
    |=> status_q[ST_POR])
    else $error("power-on flag lost without clear");
  a_int_pulls_low: assert property (status_q[ST_POR] && ctrl_q[CTRL_POWER_ON_IRQ_ENABLE]
    |=> !intPin_n)
    else $error("interrupt pin not pulled low");
  a_int_release: assert property (!status_q[ST_POR] |=> intPin_n)
    else $error("interrupt pin not released");
  a_disable_low: assert property (ctrl_q[CTRL_DIS] && !clockOutIrqFlag
    |=> !clockOut)
    else $error("clock out not low when disabled");
  a_lowv_clock: assert property (lvl_q[PIN_LOWV] |=> !clockOut && !tempSenseEn)
    else $error("low voltage did not stop clock and sensing");
  a_bus_disable: assert property (lvl_q[PIN_BUSLOW] |=> !busEnable)
    else $error("bus enabled below bus supply level");
  a_sync_enable: assert property (s_enable_wait |=> clkActive_q)
    else $error("clock out enable not taken after delay");
  a_debounce_end: assert property ($rose(mainActive) && !status_q[ST_LOWV]
    |-> $past(debCnt_q) == DEB_CYC - 1)
    else $error("recovery debounce length wrong");
  a_nco_phase: assert property ($rose(clkActive_q) |-> !nco.wave ##1 !clockOut)
    else $error("clock out did not start at phase zero");
endmodule
`default_nettype wire

// ---- inc/por_seq_pkg.sv ----
// constants for the power-on and clock-output sequencer
// assumes a single 50 MHz reference clock and AXI4-Lite register access
package por_seq_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned CLK_MHZ = 50;
  // times in microseconds, as printed
  localparam int unsigned T_POR_US = 6000;
  localparam int unsigned T_START_US = 100000;
  localparam int unsigned T_PREFR_US = 66000;
  localparam int unsigned T_DLY_32K_US = 950;
  localparam int unsigned T_DLY_1K_US = 1280;
  localparam int unsigned T_DLY_64_US = 6650;
  localparam int unsigned T_DLY_1HZ_US = 999000;
  localparam int unsigned T_DLY_HF_US = 2800;
  localparam int unsigned T_DEB_US = 1000;
  localparam int unsigned T_SAMPLE_US = 1000000;
  // cycle counts derived from the times
  localparam int unsigned POR_CYC = T_POR_US * CLK_MHZ;
  localparam int unsigned START_CYC = T_START_US * CLK_MHZ;
  localparam int unsigned DLY_32K_CYC = T_DLY_32K_US * CLK_MHZ;
  localparam int unsigned DLY_1K_CYC = T_DLY_1K_US * CLK_MHZ;
  localparam int unsigned DLY_64_CYC = T_DLY_64_US * CLK_MHZ;
  localparam int unsigned DLY_1HZ_CYC = T_DLY_1HZ_US * CLK_MHZ;
  localparam int unsigned DLY_HF_CYC = T_DLY_HF_US * CLK_MHZ;
  localparam int unsigned DEB_CYC = T_DEB_US * CLK_MHZ;
  localparam int unsigned SAMPLE_CYC = T_SAMPLE_US * CLK_MHZ;
  // phase increments of the 32-bit output synthesiser
  localparam logic [31:0] INC_32K = 32'((64'd32768 << 32) / CLK_HZ);
  localparam logic [31:0] INC_1K = 32'((64'd1024 << 32) / CLK_HZ);
  localparam logic [31:0] INC_64 = 32'((64'd64 << 32) / CLK_HZ);
  localparam logic [31:0] INC_1HZ = 32'((64'd1 << 32) / CLK_HZ);
  localparam logic [31:0] INC_HF_STEP = 32'((64'd8192 << 32) / CLK_HZ);
  localparam int HFD_W = 13;
  // register byte offsets
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_IRQ_EN = 12'h008;
  localparam logic [11:0] ADDR_IRQ_CLR = 12'h00C;
  localparam logic [11:0] ADDR_STATE = 12'h010;
  // control field positions
  localparam int CTRL_DIS = 0;
  localparam int CTRL_FD = 1;
  localparam int CTRL_OS = 3;
  localparam int CTRL_POWER_ON_IRQ_ENABLE = 4;
  localparam int CTRL_HFD = 16;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] CTRL_MASK = 32'h1FFF_001F;
  // status bits
  localparam int ST_POR = 0;
  localparam int ST_LOWV = 1;
  localparam int ST_RECOV = 2;
  localparam logic [2:0] STATUS_RST = 3'h1;
  localparam logic [2:0] IRQ_EN_RST = 3'h0;
  // synchronised pin indices
  localparam int PIN_POR = 0;
  localparam int PIN_LOWV = 1;
  localparam int PIN_BUSLOW = 2;
  localparam int PIN_BACKUP = 3;
  localparam int NPIN = 4;
  typedef enum logic [1:0] {
    FD_32K = 2'b00,
    FD_1K = 2'b01,
    FD_64 = 2'b10,
    FD_1HZ = 2'b11
  } freq_t;
  typedef enum logic [1:0] {
    SEQ_POR = 2'b00,
    SEQ_START = 2'b01,
    SEQ_RUN = 2'b11
  } seq_t;
endpackage

// ---- inc/nco_if.sv ----
// link between the sequencer and its clock-output synthesiser
// assumes both ends run on the same reference clock
`timescale 1ns/1ps
`default_nettype none
interface nco_if;
  logic [31:0] increment;
  logic hold;
  logic wave;
  modport ctl (output increment, output hold, input wave);
  modport gen (input increment, input hold, output wave);
endinterface
`default_nettype wire

// ---- core/clock_out_divider.sv ----
// phase accumulator making the square wave for the clock output
// assumes hold is raised until the output is to start in phase
`timescale 1ns/1ps
`default_nettype none
module clock_out_divider (
  input wire logic ref_clk,
  input wire logic arst_n,
  nco_if.gen nco
);
  logic [31:0] acc_q;

  // accumulator held at phase zero while not running
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      acc_q <= 32'h0000_0000;
    else if (nco.hold)
      acc_q <= 32'h0000_0000;
    else
      acc_q <= acc_q + nco.increment;
  end

  // top phase bit is the square wave
  assign nco.wave = acc_q[31];
endmodule
`default_nettype wire

// ---- verif/axi_host_model.sv ----
// host model that reaches the sequencer registers over the register bus
// assumes one clock; every wait is bounded and a stall is counted
`timescale 1ns/1ps
`default_nettype none
module axi_host_model (
  input wire logic ref_clk,
  output logic [11:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [11:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  int stalls;
  // bus idle at time zero
  initial
  begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
    stalls = 0;
  end
  // one write: address and data offered together, each held until taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
    output logic [1:0] r);
    int n;
    n = 0;
    r = 2'h3;
    @(posedge ref_clk);
    {awaddr, wdata, wstrb, awvalid, wvalid, bready} <= {a, d, 4'hF, 3'h7};
    while (n < 100)
    begin
      @(posedge ref_clk);
      n++;
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      if (bvalid)
      begin
        r = bresp;
        bready <= 1'b0;
        n = 1000;
      end
    end
    if (n < 1000)
      stalls++;
  endtask
  // one read: address held until taken, data taken with rvalid
  task automatic rd(input logic [11:0] a, output logic [31:0] d,
    output logic [1:0] r);
    int n;
    n = 0;
    {d, r} = '1;
    @(posedge ref_clk);
    {araddr, arvalid, rready} <= {a, 2'h3};
    while (n < 100)
    begin
      @(posedge ref_clk);
      n++;
      if (arready)
        arvalid <= 1'b0;
      if (rvalid)
      begin
        {d, r} = {rdata, rresp};
        rready <= 1'b0;
        n = 1000;
      end
    end
    if (n < 1000)
      stalls++;
  endtask
endmodule
`default_nettype wire

// ---- verif/power_on_clock_out_sequencer_tb.sv ----
// self-checking bench for the power-on and clock-output sequencer
// assumes the host model drives the register bus; counts are shortened
`timescale 1ns/1ps
`default_nettype none
module power_on_clock_out_sequencer_tb;
  import por_seq_pkg::*;
  localparam int DLY32 = 30;
  localparam int DEB = 16;
  localparam int SMP = 64;
  localparam int PORC = 20;
  localparam int STARTC = 40;
  localparam int DLY1K = 12;
  localparam int DLY64 = 14;
  localparam int DLY1HZ = 16;
  localparam int DLYHF = 18;
  // nonvolatile copy seen by the design at the end of start-up
  logic nvDis, nvOs, nvPorie;
  logic [1:0] nvFreq;
  logic [HFD_W-1:0] nvHfd;
  logic refClk, arstN, supplyBelowPor, supplyBelowLow, supplyBelowBus;
  logic onBackup, clockOutIrqFlag, clockOut, clockOutEn, intPin_n, irq;
  logic busEnable, tempSenseEn, mainActive;
  logic [11:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  int failCount = 0;
  int totalChecks = 0;
  // design with short phase, delay and recovery counts
  power_on_clock_out_sequencer #(
    .POR_CYC(PORC), .START_CYC(STARTC), .DLY_32K_CYC(DLY32),
    .DLY_1K_CYC(DLY1K), .DLY_64_CYC(DLY64), .DLY_1HZ_CYC(DLY1HZ),
    .DLY_HF_CYC(DLYHF), .DEB_CYC(DEB),
    .SAMPLE_CYC(SMP)
  ) i_dut (
    .ref_clk(refClk), .arst_n(arstN), .supplyBelowPor, .supplyBelowLow,
    .supplyBelowBus, .onBackup, .clockOutIrqFlag,
    .nvClockOutDisable(nvDis), .nvOutFreqSelect(nvFreq),
    .nvOscillatorSelect(nvOs), .nvPowerOnIrqEnable(nvPorie),
    .nvHighFreqDivider(nvHfd), .clockOut, .clockOutEn, .intPin_n, .irq,
    .busEnable, .tempSenseEn, .mainActive, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready
  );
  // host on the far side of the register bus
  axi_host_model i_host (
    .ref_clk(refClk), .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready
  );
  // verdict, reached from the main flow and from any spent bound
  task automatic conclude();
    failCount += i_host.stalls;
    $display("checks %0d mismatches %0d", totalChecks, failCount);
    if (failCount == 0 && totalChecks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    totalChecks++;
    if (seen !== exp)
    begin
      failCount++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bound(int n, int lim);
    if (n >= lim)
    begin
      failCount++;
      conclude();
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge refClk);
  endtask
  task automatic done(string s);
    $display("test %s finished", s);
  endtask
  // bus accesses with the response judged against the address map
  task automatic wr(logic [11:0] a, logic [31:0] d, logic [1:0] e);
    logic [1:0] r;
    i_host.wr(a, d, r);
    bound(i_host.stalls, 1);
    check("bresp", r, e);
  endtask
  task automatic rd(logic [11:0] a, output logic [31:0] d);
    logic [1:0] r;
    i_host.rd(a, d, r);
    bound(i_host.stalls, 1);
    check("rresp", r, (a > ADDR_STATE) ? 2'h2 : 2'h0);
  endtask
  // bounded wait on one watched output
  function automatic logic sig(int w);
    case (w)
      0: return clockOut;
      1: return clockOutEn;
      2: return intPin_n;
      default: return mainActive;
    endcase
  endfunction
  task automatic waitSig(int w, logic v, int lim, output int n);
    n = 0;
    while (sig(w) !== v && n < lim)
    begin
      @(posedge refClk);
      n++;
    end
    bound(n, lim);
  endtask
  task automatic period(output int p);
    int a;
    waitSig(0, 1'b0, 4000, a);
    waitSig(0, 1'b1, 4000, a);
    waitSig(0, 1'b0, 4000, a);
    waitSig(0, 1'b1, 4000, p);
    p += a;
  endtask
  task automatic quiet(int c, output logic hi);
    hi = 1'b0;
    repeat (c)
    begin
      @(posedge refClk);
      if (clockOut !== 1'b0)
        hi = 1'b1;
    end
  endtask
  task automatic testBoot();
    logic [31:0] d;
    int n;
    cyc(3);
    check("pin hi-z", clockOutEn, 1'h0);
    waitSig(1, 1'b1, 100, n);
    check("por length", n + 3 >= 18 && n + 3 <= 24, 1'h1);
    check("pin low", clockOut, 1'h0);
    rd(ADDR_STATUS, d);
    check("status boot", d, 32'h1);
    rd(ADDR_IRQ_EN, d);
    check("irq en reset", d, 32'h0);
    waitSig(2, 1'b0, 100, n);
    rd(ADDR_CTRL, d);
    check("enable mirror", d, 32'h10);
    done("boot");
  endtask
  task automatic testFlag();
    logic [31:0] d;
    cyc(200);
    rd(ADDR_STATUS, d);
    check("flag held", d[0], 1'h1);
    check("int held", intPin_n, 1'h0);
    wr(ADDR_IRQ_EN, 32'h1, 2'h0);
    cyc(3);
    check("irq on", irq, 1'h1);
    wr(ADDR_IRQ_EN, 32'h0, 2'h0);
    cyc(3);
    check("irq masked", irq, 1'h0);
    wr(ADDR_IRQ_EN, 32'h1, 2'h0);
    wr(ADDR_STATUS, 32'h0, 2'h2);
    rd(ADDR_STATUS, d);
    check("flag kept", d[0], 1'h1);
    wr(ADDR_IRQ_CLR, 32'h1, 2'h0);
    cyc(4);
    check("int released", intPin_n, 1'h1);
    check("irq cleared", irq, 1'h0);
    rd(ADDR_STATUS, d);
    check("flag cleared", d[0], 1'h0);
    rd(12'hFFC, d);
    check("unmapped", d, 32'h0);
    @(posedge refClk);
    supplyBelowPor <= 1'b1;
    cyc(8);
    supplyBelowPor <= 1'b0;
    cyc(8);
    rd(ADDR_STATUS, d);
    check("flag on drop", d[0], 1'h1);
    check("int on drop", intPin_n, 1'h0);
    wr(ADDR_IRQ_CLR, 32'h1, 2'h0);
    done("flag");
  endtask
  task automatic testFreq();
    logic [31:0] d;
    int p;
    int e;
    e = CLK_HZ / 32768;
    period(p);
    check("period 32k", p >= e - 2 && p <= e + 3, 1'h1);
    for (int i = 0; i < 4; i++)
    begin
      wr(ADDR_CTRL, 32'h10 | (i << 1), 2'h0);
      rd(ADDR_CTRL, d);
      check("freq code", d[2:1], i[1:0]);
    end
    e = CLK_HZ / (8192 * 16);
    wr(ADDR_CTRL, 32'h000F_0018, 2'h0);
    period(p);
    check("period hf", p >= e - 2 && p <= e + 3, 1'h1);
    done("freq");
  endtask
  task automatic testEnable();
    logic [31:0] d;
    logic hi;
    int n;
    time t0;
    wr(ADDR_CTRL, 32'h11, 2'h0);
    cyc(4);
    quiet(2000, hi);
    check("disabled low", hi, 1'h0);
    @(posedge refClk);
    clockOutIrqFlag <= 1'b1;
    t0 = $time;
    rd(ADDR_STATE, d);
    check("not active", d[4], 1'h0);
    waitSig(0, 1'b1, 4000, n);
    n = int'(($time - t0) / 20);
    check("sync delay", n >= DLY32 + 758 && n <= DLY32 + 772, 1'h1);
    rd(ADDR_STATE, d);
    check("active", d[4], 1'h1);
    clockOutIrqFlag <= 1'b0;
    cyc(2);
    quiet(1600, hi);
    check("low again", hi, 1'h0);
    wr(ADDR_CTRL, 32'h10, 2'h0);
    done("enable");
  endtask
  task automatic testSupply();
    logic [31:0] d;
    logic hi;
    int n;
    @(posedge refClk);
    supplyBelowLow <= 1'b1;
    cyc(8);
    check("sense off", tempSenseEn, 1'h0);
    quiet(1600, hi);
    check("clock forced low", hi, 1'h0);
    rd(ADDR_CTRL, d);
    check("regs kept", d, 32'h10);
    supplyBelowLow <= 1'b0;
    cyc(8);
    check("sense on", tempSenseEn, 1'h1);
    wr(ADDR_CTRL, 32'h10, 2'h0);
    supplyBelowBus <= 1'b1;
    cyc(8);
    check("bus off", busEnable, 1'h0);
    supplyBelowBus <= 1'b0;
    cyc(8);
    check("bus on", busEnable, 1'h1);
    for (int k = 0; k < 2; k++)
    begin
      onBackup <= 1'b1;
      cyc(8);
      check("on backup", mainActive, 1'h0);
      onBackup <= 1'b0;
      waitSig(3, 1'b1, 200, n);
      if (k == 0)
        check("sampled return", n <= SMP + 8, 1'h1);
      else
        check("debounce", n >= DEB && n <= DEB + 8, 1'h1);
      rd(ADDR_STATUS, d);
      check("recovered", d[2], 1'h1);
      wr(ADDR_IRQ_CLR, 32'h6, 2'h0);
    end
    done("supply");
  endtask
  // second reset with another nonvolatile copy
  task automatic testRestart();
    logic [31:0] d;
    logic hi;
    @(posedge refClk);
    nvDis <= 1'b1;
    nvFreq <= 2'h1;
    nvOs <= 1'b1;
    nvPorie <= 1'b0;
    nvHfd <= 13'h5;
    arstN <= 1'b0;
    cyc(4);
    arstN <= 1'b1;
    cyc(3);
    check("hi-z again", clockOutEn, 1'h0);
    cyc(PORC + STARTC);
    rd(ADDR_STATUS, d);
    check("flag after reset", d, 32'h1);
    rd(ADDR_CTRL, d);
    check("nv load", d, 32'h0005_000B);
    check("int kept high", intPin_n, 1'h1);
    quiet(40, hi);
    check("nv disable low", hi, 1'h0);
    done("restart");
  endtask
  // free-running 50 MHz clock
  initial
  begin
    refClk = 1'b0;
    forever #10 refClk = ~refClk;
  end
  // cuts a hang short
  initial
  begin
    repeat (100000) @(posedge refClk);
    failCount++;
    conclude();
  end
  // main sequence
  initial
  begin
    {arstN, supplyBelowPor, supplyBelowLow} = '0;
    {supplyBelowBus, onBackup, clockOutIrqFlag} = '0;
    {nvDis, nvFreq, nvOs, nvHfd} = '0;
    nvPorie = 1'b1;
    repeat (4) @(posedge refClk);
    arstN <= 1'b1;
    testBoot();
    testFlag();
    testFreq();
    testEnable();
    testSupply();
    testRestart();
    conclude();
  end
endmodule
`default_nettype wire
